//--- design/uart_port.v
// byte-wide serial port with 16-byte receive and transmit buffers,
// eight-byte register window and a shareable open-drain interrupt.
// assumes host strobes are synchronous to clk_i; serial and modem pins
// are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
`include "uart_port_defs.vh"

module uart_port (
    input  wire                 clk_i,
    input  wire                 rst_i,
    input  wire                 sel_i,
    input  wire [`ADDR_W-1:0]   addr_i,
    input  wire                 rd_i,
    input  wire                 wr_i,
    input  wire [`BYTE_W-1:0]   wdata_i,
    output reg  [`BYTE_W-1:0]   rdata_o,
    input  wire                 rxd_i,
    output reg                  txd_o,
    input  wire                 cts_i,
    input  wire                 dsr_i,
    input  wire                 ri_i,
    input  wire                 dcd_i,
    output reg                  irq_n_o,
    output reg                  irq_n_oe_o,
    output reg                  irq_pending_o
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_STRT = 5'h02;
    localparam [4:0] S_DATA = 5'h04;
    localparam [4:0] S_PAR  = 5'h08;
    localparam [4:0] S_STOP = 5'h10;

    function [`PTR_W-1:0] inc_ptr;
        input [`PTR_W-1:0] p;
        begin
            inc_ptr = p + 1'b1;
        end
    endfunction

    function [`CNT_W-1:0] trig_level;
        input [1:0] code;
        begin
            case (code)
                2'h0:    trig_level = `TRIG_1;
                2'h1:    trig_level = `TRIG_4;
                2'h2:    trig_level = `TRIG_8;
                default: trig_level = `TRIG_14;
            endcase
        end
    endfunction

    // ======================================================================
    // pin synchronisers
    reg [4:0] pin_meta_ff;
    reg [4:0] pin_ff;
    always @(posedge clk_i) begin
        pin_meta_ff <= {rxd_i, cts_i, dsr_i, ri_i, dcd_i};
        pin_ff      <= pin_meta_ff;
    end
    wire       rxd_s   = pin_ff[4];
    wire [3:0] modem_s = pin_ff[3:0];

    // ======================================================================
    // registers and host access decode
    reg  [`BYTE_W-1:0] line_ctl_ff, ier_ff, scratch_ff, modem_ctl_ff;
    reg  [`DIV_W-1:0]  div_ff;
    reg                buf_en_ff;
    reg  [1:0]         trig_ff;
    reg  [`CNT_W-1:0]  rx_cnt_ff, tx_cnt_ff;
    reg  [`PTR_W-1:0]  rx_rp_ff, rx_wp_ff, tx_rp_ff, tx_wp_ff;
    reg                oe_ff, pe_ff, fe_ff, thre_int_ff;
    reg  [3:0]         msr_delta_ff, modem_last_ff;
    reg                tx_busy_ff;

    wire divacc = line_ctl_ff[`LC_DIVACC_BIT];
    wire rd_hit = sel_i & rd_i;
    wire wr_hit = sel_i & wr_i;
    // divisor bytes replace data and enable at offsets zero and one
    wire div_win = divacc & (addr_i == `OFS_DATA || addr_i == `OFS_IER);
    wire wr_data = wr_hit & ~divacc & (addr_i == `OFS_DATA);
    wire rd_data = rd_hit & ~divacc & (addr_i == `OFS_DATA);
    wire wr_buf  = wr_hit & (addr_i == `OFS_IID_BUF);
    wire rd_iid  = rd_hit & (addr_i == `OFS_IID_BUF);
    wire rd_ls   = rd_hit & (addr_i == `OFS_LINE_STAT);
    wire rd_ms   = rd_hit & (addr_i == `OFS_MODEM_STAT);
    wire [`CNT_W-1:0] depth = buf_en_ff ? `FIFO_DEPTH : `SINGLE_DEPTH;

    // ======================================================================
    // buffer control: enable, resets, threshold
    wire buf_on_req = (wdata_i[3:0] == `BUF_LOW_NIBBLE);
    wire mode_chg   = wr_buf & (buf_on_req != buf_en_ff);
    wire rx_clr = wr_buf & (wdata_i[`BUF_RXRST_BIT] | mode_chg);
    wire tx_clr = wr_buf & (wdata_i[`BUF_TXRST_BIT] | mode_chg);
    always @(posedge clk_i) begin
        if (rst_i) begin
            buf_en_ff <= 1'b0;
            trig_ff   <= 2'h0;
        end else if (wr_buf) begin
            buf_en_ff <= buf_on_req;
            trig_ff   <= wdata_i[`BUF_TRIG_HI:`BUF_TRIG_LO];
        end
    end

    // ======================================================================
    // receive and transmit buffers
    wire              rx_push, tx_pop;
    wire [`BYTE_W-1:0] rx_byte, rx_head, tx_head;
    wire rx_full = (rx_cnt_ff >= depth);
    wire rx_we   = rx_push & ~rx_full;
    wire rx_pop  = rd_data & (rx_cnt_ff != 5'h00);
    wire tx_we   = wr_data & (tx_cnt_ff < depth);
    wire [`PTR_W-1:0] rx_rp_nxt = rx_pop ? inc_ptr(rx_rp_ff) : rx_rp_ff;
    wire [`PTR_W-1:0] tx_rp_nxt = tx_pop ? inc_ptr(tx_rp_ff) : tx_rp_ff;

    fifo_store u_rx_store (
        .clk_i  (clk_i),
        .we_i   (rx_we),
        .waddr_i(rx_wp_ff),
        .wdata_i(rx_byte),
        .raddr_i(rx_rp_nxt),
        .rdata_o(rx_head)
    );
    fifo_store u_tx_store (
        .clk_i  (clk_i),
        .we_i   (tx_we),
        .waddr_i(tx_wp_ff),
        .wdata_i(wdata_i),
        .raddr_i(tx_rp_nxt),
        .rdata_o(tx_head)
    );

    always @(posedge clk_i) begin
        if (rst_i || rx_clr) begin
            rx_rp_ff  <= 4'h0;
            rx_wp_ff  <= 4'h0;
            rx_cnt_ff <= 5'h00;
        end else begin
            rx_rp_ff  <= rx_rp_nxt;
            rx_wp_ff  <= rx_we ? inc_ptr(rx_wp_ff) : rx_wp_ff;
            rx_cnt_ff <= rx_cnt_ff + {4'h0, rx_we} - {4'h0, rx_pop};
        end
        if (rst_i || tx_clr) begin
            tx_rp_ff  <= 4'h0;
            tx_wp_ff  <= 4'h0;
            tx_cnt_ff <= 5'h00;
        end else begin
            tx_rp_ff  <= tx_rp_nxt;
            tx_wp_ff  <= tx_we ? inc_ptr(tx_wp_ff) : tx_wp_ff;
            tx_cnt_ff <= tx_cnt_ff + {4'h0, tx_we} - {4'h0, tx_pop};
        end
    end

    // ======================================================================
    // register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            line_ctl_ff  <= `LINE_CTL_RST;
            ier_ff       <= `IER_RST;
            scratch_ff   <= `BYTE_ZERO;
            modem_ctl_ff <= `BYTE_ZERO;
            div_ff       <= `DIV_RST;
        end else if (wr_hit) begin
            case (addr_i)
                `OFS_DATA:      if (divacc) div_ff[7:0] <= wdata_i;
                `OFS_IER:       if (divacc) div_ff[15:8] <= wdata_i;
                                else ier_ff <= wdata_i;
                `OFS_LINE_CTL:  line_ctl_ff <= wdata_i;
                `OFS_MODEM_CTL: modem_ctl_ff <= wdata_i;
                `OFS_SCRATCH:   scratch_ff <= wdata_i;
                default:        ;
            endcase
        end
    end

    // ======================================================================
    // baud tick at 16 per bit: clk_i divided by the divisor
    reg  [`DIV_W-1:0] baud_cnt_ff;
    wire tick = (baud_cnt_ff >= div_ff - 16'h0001);
    always @(posedge clk_i) begin
        if (rst_i || tick) begin
            baud_cnt_ff <= 16'h0000;
        end else begin
            baud_cnt_ff <= baud_cnt_ff + 16'h0001;
        end
    end

    wire [2:0] wlen_last = {1'b0, line_ctl_ff[`LC_WLEN_HI:`LC_WLEN_LO]}
                           + `WLEN_BASE;
    wire par_en   = line_ctl_ff[`LC_PAR_EN_BIT];
    wire par_even = line_ctl_ff[`LC_PAR_EVEN_BIT];

    // ======================================================================
    // transmitter
    reg [4:0]         tx_st_ff;
    reg [3:0]         tx_tk_ff;
    reg [2:0]         tx_bit_ff;
    reg [`BYTE_W-1:0] tx_sh_ff;
    reg               tx_par_ff, tx_stop2_ff;
    assign tx_pop = (tx_st_ff == S_IDLE) & (tx_cnt_ff != 5'h00) & ~tx_clr;
    wire tx_bit_end = tick & (tx_tk_ff == `TICKS_LAST);
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_ff    <= S_IDLE;
            tx_tk_ff    <= 4'h0;
            tx_bit_ff   <= 3'h0;
            tx_sh_ff    <= `BYTE_ZERO;
            tx_par_ff   <= 1'b0;
            tx_stop2_ff <= 1'b0;
            txd_o       <= 1'b1;
        end else begin
            if (tick) tx_tk_ff <= tx_tk_ff + 4'h1;
            case (tx_st_ff)
                S_IDLE: if (tx_pop) begin
                    tx_sh_ff    <= tx_head;
                    tx_par_ff   <= ~par_even;
                    tx_bit_ff   <= 3'h0;
                    tx_tk_ff    <= 4'h0;
                    tx_stop2_ff <= line_ctl_ff[`LC_STOP_BIT];
                    txd_o       <= 1'b0;
                    tx_st_ff    <= S_STRT;
                end
                S_STRT: if (tx_bit_end) begin
                    txd_o    <= tx_sh_ff[0];
                    tx_st_ff <= S_DATA;
                end
                S_DATA: if (tx_bit_end) begin
                    tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
                    tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                    tx_bit_ff <= tx_bit_ff + 3'h1;
                    if (tx_bit_ff == wlen_last) begin
                        txd_o    <= par_en ? (tx_par_ff ^ tx_sh_ff[0])
                                           : 1'b1;
                        tx_st_ff <= par_en ? S_PAR : S_STOP;
                    end else begin
                        txd_o <= tx_sh_ff[1];
                    end
                end
                S_PAR: if (tx_bit_end) begin
                    txd_o    <= 1'b1;
                    tx_st_ff <= S_STOP;
                end
                S_STOP: if (tx_bit_end) begin
                    if (tx_stop2_ff) tx_stop2_ff <= 1'b0;
                    else tx_st_ff <= S_IDLE;
                end
                default: tx_st_ff <= S_IDLE;
            endcase
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) tx_busy_ff <= 1'b0;
        else tx_busy_ff <= (tx_st_ff != S_IDLE) | tx_pop;
    end

    // ======================================================================
    // receiver: start bit confirmed at half a bit, data sampled mid-bit
    reg [4:0]         rx_st_ff;
    reg [3:0]         rx_tk_ff;
    reg [2:0]         rx_bit_ff;
    reg [`BYTE_W-1:0] rx_sh_ff;
    reg               rx_par_ff, rx_perr_ff, rx_done_ff, rx_ferr_ff;
    wire rx_mid = tick & (rx_tk_ff == `TICKS_LAST);
    assign rx_push = rx_done_ff;
    // short words land right-aligned with zeros above
    assign rx_byte = rx_sh_ff >> (3'h7 - wlen_last);
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_ff   <= S_IDLE;
            rx_tk_ff   <= 4'h0;
            rx_bit_ff  <= 3'h0;
            rx_sh_ff   <= `BYTE_ZERO;
            rx_par_ff  <= 1'b0;
            rx_perr_ff <= 1'b0;
            rx_ferr_ff <= 1'b0;
            rx_done_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            if (tick) rx_tk_ff <= rx_tk_ff + 4'h1;
            case (rx_st_ff)
                S_IDLE: if (~rxd_s) begin
                    rx_tk_ff <= 4'h0;
                    rx_st_ff <= S_STRT;
                end
                S_STRT: if (tick && rx_tk_ff == `TICKS_HALF) begin
                    rx_tk_ff  <= 4'h0;
                    rx_bit_ff <= 3'h0;
                    rx_par_ff <= ~par_even;
                    rx_st_ff  <= rxd_s ? S_IDLE : S_DATA;
                end
                S_DATA: if (rx_mid) begin
                    rx_sh_ff  <= {rxd_s, rx_sh_ff[7:1]};
                    rx_par_ff <= rx_par_ff ^ rxd_s;
                    rx_bit_ff <= rx_bit_ff + 3'h1;
                    if (rx_bit_ff == wlen_last)
                        rx_st_ff <= par_en ? S_PAR : S_STOP;
                end
                S_PAR: if (rx_mid) begin
                    rx_perr_ff <= rx_par_ff ^ rxd_s;
                    rx_st_ff   <= S_STOP;
                end
                S_STOP: if (rx_mid) begin
                    rx_ferr_ff <= ~rxd_s;
                    rx_done_ff <= 1'b1;
                    rx_st_ff   <= S_IDLE;
                end
                default: rx_st_ff <= S_IDLE;
            endcase
            if (rx_st_ff == S_STRT) rx_perr_ff <= 1'b0;
        end
    end

    // ======================================================================
    // sticky status: a new event wins over the clearing read
    wire tx_empty_evt = tx_pop & (tx_cnt_ff == 5'h01) & ~tx_we;
    wire ms_change    = |(modem_s ^ modem_last_ff);
    wire [2:0] iid_now;
    always @(posedge clk_i) begin
        if (rst_i) begin
            oe_ff         <= 1'b0;
            pe_ff         <= 1'b0;
            fe_ff         <= 1'b0;
            msr_delta_ff  <= 4'h0;
            modem_last_ff <= 4'h0;
            thre_int_ff   <= 1'b0;
        end else begin
            oe_ff <= (rx_push & rx_full) | (oe_ff & ~rd_ls);
            pe_ff <= (rx_push & rx_perr_ff) | (pe_ff & ~rd_ls);
            fe_ff <= (rx_push & rx_ferr_ff) | (fe_ff & ~rd_ls);
            modem_last_ff <= modem_s;
            msr_delta_ff  <= (modem_s ^ modem_last_ff)
                             | (msr_delta_ff & {4{~rd_ms}});
            // one request per emptied buffer, i.e. per up to 16 bytes
            if (tx_empty_evt)
                thre_int_ff <= 1'b1;
            else if (wr_data || (rd_iid && iid_now == `IID_TXEMPTY))
                thre_int_ff <= 1'b0;
            else if (wr_hit && addr_i == `OFS_IER && !divacc &&
                     wdata_i[`IER_TX_BIT] && !ier_ff[`IER_TX_BIT] &&
                     tx_cnt_ff == 5'h00)
                thre_int_ff <= 1'b1;
        end
    end

    // ======================================================================
    // interrupt sources in priority order
    wire rx_lvl = buf_en_ff ? (rx_cnt_ff >= trig_level(trig_ff))
                            : (rx_cnt_ff != 5'h00);
    wire src_ls = ier_ff[`IER_LS_BIT] & (oe_ff | pe_ff | fe_ff);
    wire src_rx = ier_ff[`IER_RX_BIT] & rx_lvl;
    wire src_tx = ier_ff[`IER_TX_BIT] & thre_int_ff;
    wire src_ms = ier_ff[`IER_MS_BIT] & (|msr_delta_ff);
    assign iid_now = src_ls ? `IID_LINE :
                     src_rx ? `IID_RXDATA :
                     src_tx ? `IID_TXEMPTY :
                     src_ms ? `IID_MODEM : `IID_NONE;
    wire any_src = src_ls | src_rx | src_tx | src_ms;

    // open drain: value held low, only the enable moves
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_n_o       <= 1'b0;
            irq_n_oe_o    <= 1'b0;
            irq_pending_o <= 1'b0;
        end else begin
            irq_n_o       <= 1'b0;
            irq_n_oe_o    <= any_src;
            irq_pending_o <= any_src;
        end
    end

    // ======================================================================
    // read data; modem and line status read as idle-true values
    wire [`BYTE_W-1:0] line_stat = {1'b0,
        (tx_cnt_ff == 5'h00) & ~tx_busy_ff, tx_cnt_ff == 5'h00, 1'b0,
        fe_ff, pe_ff, oe_ff, rx_cnt_ff != 5'h00};
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= `BYTE_ZERO;
        end else if (rd_hit) begin
            case (addr_i)
                `OFS_DATA:       rdata_o <= div_win ? div_ff[7:0]
                                                    : rx_head;
                `OFS_IER:        rdata_o <= div_win ? div_ff[15:8] : ier_ff;
                `OFS_IID_BUF:    rdata_o <= {buf_en_ff ? `IID_BUF_FLAGS
                                                       : 2'h0,
                                             3'h0, iid_now};
                `OFS_LINE_CTL:   rdata_o <= line_ctl_ff;
                `OFS_MODEM_CTL:  rdata_o <= modem_ctl_ff;
                `OFS_LINE_STAT:  rdata_o <= line_stat;
                `OFS_MODEM_STAT: rdata_o <= {modem_s, msr_delta_ff};
                default:         rdata_o <= scratch_ff;
            endcase
        end
    end
endmodule // uart_port

`default_nettype wire

//--- shared/uart_port_defs.vh
// constants for the buffered serial port: register offsets, field
// positions, reset values and encodings shared by the design files.
// assumes plain Verilog-2005 and inclusion by bare name.
`ifndef UART_PORT_DEFS_VH
`define UART_PORT_DEFS_VH

// ==========================================================================
// geometry
`define BYTE_W          8
`define ADDR_W          3
`define PTR_W           4
`define CNT_W           5
`define FIFO_DEPTH      5'h10
`define SINGLE_DEPTH    5'h01
`define DIV_W           16

// ==========================================================================
// register offsets inside the eight-byte window
`define OFS_DATA        3'h0
`define OFS_IER         3'h1
`define OFS_IID_BUF     3'h2
`define OFS_LINE_CTL    3'h3
`define OFS_MODEM_CTL   3'h4
`define OFS_LINE_STAT   3'h5
`define OFS_MODEM_STAT  3'h6
`define OFS_SCRATCH     3'h7

// ==========================================================================
// field positions
`define BUF_EN_BIT      0
`define BUF_RXRST_BIT   1
`define BUF_TXRST_BIT   2
`define BUF_TRIG_HI     7
`define BUF_TRIG_LO     6
`define IER_RX_BIT      0
`define IER_TX_BIT      1
`define IER_LS_BIT      2
`define IER_MS_BIT      3
`define LC_WLEN_HI      1
`define LC_WLEN_LO      0
`define LC_STOP_BIT     2
`define LC_PAR_EN_BIT   3
`define LC_PAR_EVEN_BIT 4
`define LC_DIVACC_BIT   7
`define BUF_LOW_NIBBLE  4'h1

// ==========================================================================
// reset values and fixed read patterns
`define LINE_CTL_RST    8'h00
`define IER_RST         8'h00
`define DIV_RST         16'h0001
`define BYTE_ZERO       8'h00
`define IID_BUF_FLAGS   2'h3
`define IID_NONE        3'h1
`define IID_LINE        3'h6
`define IID_RXDATA      3'h4
`define IID_TXEMPTY     3'h2
`define IID_MODEM       3'h0

// ==========================================================================
// receive thresholds and bit timing (16 ticks per serial bit)
`define TRIG_1          5'h01
`define TRIG_4          5'h04
`define TRIG_8          5'h08
`define TRIG_14         5'h0E
`define TICKS_LAST      4'hF
`define TICKS_HALF      4'h7
`define WLEN_BASE       3'h4

`endif

//--- design/fifo_store.v
// sixteen-byte storage for one direction of the serial port.
// assumes one clock; read data always come out of a register.
`timescale 1ns/1ps
`default_nettype none
`include "uart_port_defs.vh"

module fifo_store (
    input  wire                 clk_i,
    input  wire                 we_i,
    input  wire [`PTR_W-1:0]    waddr_i,
    input  wire [`BYTE_W-1:0]   wdata_i,
    input  wire [`PTR_W-1:0]    raddr_i,
    output reg  [`BYTE_W-1:0]   rdata_o
);
    reg [`BYTE_W-1:0] mem [0:15];

    // write-through so a byte landing on the head is visible at once
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // fifo_store

`default_nettype wire

//--- verif/uart_port_sva.sv
// checker for the serial port register window and interrupt pins.
// assumes a bind onto uart_port; one clock, synchronous reset high.
`timescale 1ns/1ps
`default_nettype none
module uart_port_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       sel_i,
    input wire logic [2:0] addr_i,
    input wire logic       rd_i,
    input wire logic       wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_n_o,
    input wire logic       irq_n_oe_o,
    input wire logic       irq_pending_o
);
    // ====
    // shadow of the mode bits, rebuilt from host writes
    logic div_ff;
    logic buf_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 1'b0;
            buf_ff <= 1'b0;
        end else if (sel_i && wr_i) begin
            if (addr_i == 3'h3) div_ff <= wdata_i[7];
            if (addr_i == 3'h2) buf_ff <= wdata_i[3:0] == 4'h1;
        end
    end
    // ====
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wr_at(a, en);
        sel_i && wr_i && addr_i == a && en;
    endsequence
    sequence echo(a, en);
        wr_at(a, en) ##1 (sel_i && rd_i && addr_i == a);
    endsequence
    scratch_echo_a: assert property (
        echo(3'h7, 1'b1) |=> rdata_o == $past(wdata_i, 2))
        else $error("scratch read differs");
    line_echo_a: assert property (
        echo(3'h3, 1'b1) |=> rdata_o == $past(wdata_i, 2))
        else $error("line control read differs");
    div_low_a: assert property (
        echo(3'h0, div_ff) |=> rdata_o == $past(wdata_i, 2))
        else $error("divisor low read differs");
    div_high_a: assert property (
        echo(3'h1, div_ff) |=> rdata_o == $past(wdata_i, 2))
        else $error("divisor high read differs");
    buf_flags_a: assert property (
        sel_i && rd_i && addr_i == 3'h2 |=>
        rdata_o[7:6] == {2{$past(buf_ff)}})
        else $error("buffer flags wrong");
    pend_level_a: assert property (
        irq_n_oe_o == irq_pending_o)
        else $error("pending latch and line drive differ");
    drain_low_a: assert property (
        irq_n_oe_o |-> !irq_n_o)
        else $error("driven interrupt line not low");
    ier_off_a: assert property (
        wr_at(3'h1, !div_ff && wdata_i == 8'h00) ##1 (!wr_i)[*2]
        |=> !irq_pending_o)
        else $error("interrupt pending with sources off");
endmodule // uart_port_sva
`default_nettype wire

//--- verif/line_far_end.sv
// far side of the port: serial line looped back, shared request line.
// assumes the port drives txd idle high and the line is pulled up.
`timescale 1ns/1ps
`default_nettype none
module line_far_end (
    input  wire logic txd_i,
    input  wire logic irq_n_i,
    input  wire logic irq_n_oe_i,
    output logic      rxd_o,
    output logic      irq_line_o
);
    assign rxd_o      = txd_i;
    // released line floats to the pull-up, never to a stale value
    // one request line shared by several windows; others release it here
    assign irq_line_o = irq_n_oe_i ? irq_n_i : 1'b1;
endmodule // line_far_end
`default_nettype wire

//--- verif/testbench.sv
// bench: host register accesses, serial loopback and the shared line.
// assumes uart_port, line_far_end and uart_port_sva are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk_i   = 1'b0;
    logic       rst_i   = 1'b1;
    logic       sel_i   = 1'b0;
    logic [2:0] addr_i  = 3'h0;
    logic       rd_i    = 1'b0;
    logic       wr_i    = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic       rxd, txd, irq_n, irq_oe, pend, irq_wire;
    logic       quiet   = 1'b0;
    int         mismatches = 0;
    int         n_checks   = 0;
    // ====
    // design and far end
    uart_port dut_u (.clk_i, .rst_i, .sel_i, .addr_i, .rd_i, .wr_i,
        .wdata_i, .rdata_o, .rxd_i(rxd), .txd_o(txd), .cts_i(quiet),
        .dsr_i(quiet), .ri_i(quiet), .dcd_i(quiet), .irq_n_o(irq_n),
        .irq_n_oe_o(irq_oe), .irq_pending_o(pend));
    line_far_end far_u (.txd_i(txd), .irq_n_i(irq_n),
        .irq_n_oe_i(irq_oe), .rxd_o(rxd), .irq_line_o(irq_wire));
    initial forever #2.5 clk_i = ~clk_i;
    // ====
    // host access tasks
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sel_i   <= 1'b1;
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
        addr_i  <= a;
        wdata_i <= d;
    endtask
    // read is taken one edge after set-up; data settle after that edge
    task automatic get(input logic [2:0] a, input logic [7:0] e,
                       input string nm);
        @(posedge clk_i);
        sel_i  <= 1'b1;
        wr_i   <= 1'b0;
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        sel_i <= 1'b0;
        rd_i  <= 1'b0;
        #1;
        chk(nm, e, rdata_o);
    endtask
    task automatic idle;
        @(posedge clk_i);
        sel_i <= 1'b0;
        wr_i  <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ====
    // tests
    initial begin
        int i;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("idle txd", 8'h01, {7'h0, txd});
        put(3'h7, 8'hAA);
        get(3'h7, 8'hAA, "scratch");
        put(3'h3, 8'h80);
        put(3'h1, 8'h00);
        get(3'h1, 8'h00, "divisor high");
        put(3'h0, 8'h30);
        get(3'h0, 8'h30, "divisor low");
        put(3'h3, 8'h03);
        get(3'h3, 8'h03, "line control");
        get(3'h1, 8'h00, "enable map");
        put(3'h1, 8'h00);
        get(3'h5, 8'h60, "line status");
        get(3'h6, 8'h00, "modem status");
        get(3'h2, 8'h01, "id plain");
        put(3'h2, 8'h01);
        get(3'h2, 8'hC1, "id buffered");
        $display("test init done");
        put(3'h1, 8'h01);
        put(3'h0, 8'h5A);
        idle;
        for (i = 0; i < 12000 && pend !== 1'b1; i++) @(negedge clk_i);
        chk("line low", 8'h00, {7'h0, irq_wire});
        chk("pending", 8'h01, {7'h0, pend});
        get(3'h2, 8'hC4, "id rx");
        put(3'h1, 8'h00);
        idle;
        repeat (3) @(negedge clk_i);
        chk("line freed", 8'h01, {7'h0, irq_wire});
        get(3'h0, 8'h5A, "rx byte");
        // the echo lands mid stop bit, while the transmitter still sends it
        repeat (800) @(posedge clk_i);
        get(3'h5, 8'h60, "status drained");
        // buffer already drained: enabling the source raises it at once
        put(3'h1, 8'h02);
        get(3'h2, 8'hC2, "id tx empty");
        chk("tx pending", 8'h01, {7'h0, pend});
        get(3'h2, 8'hC1, "id tx served");
        put(3'h1, 8'h00);
        idle;
        $display("test loopback done");
        tally_and_finish;
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        tally_and_finish;
    end
endmodule // testbench
bind uart_port uart_port_sva chk_u (.clk_i, .rst_i, .sel_i, .addr_i,
    .rd_i, .wr_i, .wdata_i, .rdata_o, .irq_n_o, .irq_n_oe_o,
    .irq_pending_o);
`default_nettype wire
